// ### design/vol_pkg.sv
/*
 * Constants for the audio volume and mute register bank: register
 * addresses, field positions, reset values and soft-step timing.
 * Assumes a 25 MHz system clock.
 */
package vol_pkg;
   localparam logic [3:0]  ADDR_PLAYBACK_GAIN = 4'h2;
   localparam logic [3:0]  ADDR_LOOP_GAIN     = 4'h3;
   localparam int          ADDR_W             = 4;
   localparam int          DATA_W             = 16;
   localparam int          GAIN_W             = 7;
   localparam int          LEFT_MUTE_BIT      = 15;
   localparam int          LEFT_GAIN_LSB      = 8;
   localparam int          RIGHT_MUTE_BIT     = 7;
   localparam int          RIGHT_GAIN_LSB     = 0;
   localparam logic [6:0]  PLAY_GAIN_RESET    = 7'h7F;
   localparam logic [6:0]  PLAY_GAIN_MIN      = 7'h00;
   localparam logic [6:0]  LOOP_GAIN_RESET    = 7'h67;
   localparam logic [6:0]  LOOP_GAIN_MIN      = 7'h20;
   localparam logic [15:0] PLAY_REG_RESET     = 16'hFFFF;
   localparam logic [15:0] LOOP_REG_RESET     = 16'hE7E7;
   localparam int          CLK_HZ             = 25000000;
   localparam int          STEP_NORMAL_US     = 20;
   localparam int          STEP_HALF_US       = 40;
   localparam int          STEP_NORMAL_CYC    = STEP_NORMAL_US * (CLK_HZ / 1000000);
   localparam int          STEP_HALF_CYC      = STEP_HALF_US * (CLK_HZ / 1000000);
   localparam int          TICK_W             = 10;
endpackage

// ### design/gain_ramp.sv
/*
 * One soft-stepped gain channel: walks the live gain code one step per
 * tick toward the stored code, or toward the floor while muted, and
 * raises silence once parked on the floor under mute.
 * Assumes a one-cycle tick from the parent's shared step timer.
 */
`timescale 1ns/10ps
`default_nettype none
module gain_ramp #(
   parameter logic [6:0] FLOOR     = 7'h00,
   parameter logic [6:0] START     = 7'h7F
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       tick,
   input  wire logic       mute_req,
   input  wire logic [6:0] target,
   output logic      [6:0] live_gain,
   output logic            silenced,
   output logic            settled
);
   logic [6:0] goal;

   // Codes under the floor behave as mute too
   always_comb begin
      goal = (mute_req || target < FLOOR) ? FLOOR : target;
   end

   // Start at the floor muted, so an unmute ramps up from the bottom
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         live_gain <= FLOOR;
      end else if (tick && live_gain < goal) begin
         live_gain <= live_gain + 7'h01;
      end else if (tick && live_gain > goal) begin
         live_gain <= live_gain - 7'h01;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         silenced <= 1'b1;
      end else begin
         silenced <= (mute_req || target < FLOOR) && live_gain == FLOOR;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         settled <= 1'b1;
      end else begin
         settled <= live_gain == goal;
      end
   end
endmodule
`default_nettype wire

// ### design/audio_volume_mute_regs.sv
/*
 * Playback and analog loop volume register bank with soft-stepped mute.
 * Holds two 16-bit registers written and read over a simple synchronous
 * register port, and drives live gain codes and path cut flags to the
 * converters and analog loop. Assumes a 25 MHz clock and a host that
 * presents one access per cycle with wr_en or rd_en high.
 */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Left playback mute ramps left gain to floor, then feeds zeros to the filter.
// - Stored left playback gain is kept during mute; unmute ramps back to it.
// - Left playback gain is bits 14..8, 0.5 dB steps, 7Fh 0 dB, 00h -63.5 dB.
// - Right playback mute (bit 7) ramps to floor, then zeros; stored code kept.
// - Right playback gain is bits 6..0, 0.5 dB steps, 7Fh 0 dB, 00h -63.5 dB.
// - Reset: both playback mutes set, both playback gains 1111111 (0 dB).
// - Left loop mute ramps left loop gain to floor, then cuts line-in to outputs.
// - Left loop gain bits 14..8: 7Fh +12 dB, 67h 0 dB, 20h -35.5 dB.
// - Any loop gain code below 20h mutes that channel like its mute bit.
// - Right loop mute (bit 7) ramps to floor, then silences right loop path.
// - Right loop gain bits 6..0: 7Fh +12 dB, 67h 0 dB, 20h -35.5 dB.
// - Reset: both loop mutes set, both loop gains 1100111 (unity).
// - Clearing a loop mute ramps gain back up to the retained code.
// - One ramp step every 20 us, or 40 us with half-rate select set.
// - Read-only done flag is 1 when all ramps finished, 0 while ramping.
module audio_volume_mute_regs
   import vol_pkg::*;
#(
   parameter int STEP_NORMAL = STEP_NORMAL_CYC,
   parameter int STEP_HALF   = STEP_HALF_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic [vol_pkg::ADDR_W-1:0] addr,
   input  wire logic                  wr_en,
   input  wire logic [vol_pkg::DATA_W-1:0] wr_data,
   input  wire logic                  rd_en,
   output logic      [vol_pkg::DATA_W-1:0] rd_data,
   input  wire logic                  ramp_half_rate_select,
   output logic                       ramp_done_flag,
   output logic      [6:0]            left_playback_level,
   output logic      [6:0]            right_playback_level,
   output logic                       left_playback_zero,
   output logic                       right_playback_zero,
   output logic      [6:0]            left_loop_level,
   output logic      [6:0]            right_loop_level,
   output logic                       left_loop_cut,
   output logic                       right_loop_cut
);
   import vol_pkg::*;

   logic [DATA_W-1:0] playback_digital_gain;
   logic [DATA_W-1:0] analog_loop_gain;
   logic [TICK_W-1:0] tick_count;
   logic              tick;
   logic [3:0]        settled;

   // Mute bits and gain codes share one register; stored codes never move
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         playback_digital_gain <= PLAY_REG_RESET;
      end else if (wr_en && addr == ADDR_PLAYBACK_GAIN) begin
         playback_digital_gain <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         analog_loop_gain <= LOOP_REG_RESET;
      end else if (wr_en && addr == ADDR_LOOP_GAIN) begin
         analog_loop_gain <= wr_data;
      end
   end

   // Unmapped reads return zero; value lands one cycle after rd_en
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= '0;
      end else if (rd_en) begin
         case (addr)
            ADDR_PLAYBACK_GAIN: rd_data <= playback_digital_gain;
            ADDR_LOOP_GAIN:     rd_data <= analog_loop_gain;
            default:            rd_data <= '0;
         endcase
      end
   end

   // Shared step timer; the rate select is applied combinationally on every cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_count <= '0;
      end else if (tick) begin
         tick_count <= '0;
      end else begin
         tick_count <= tick_count + 1'b1;
      end
   end

   // Compare with >= so a drop to the normal rate while the count is already
   // past the short limit wraps at once instead of running round the counter
   always_comb begin
      tick = ramp_half_rate_select
           ? (tick_count >= TICK_W'(STEP_HALF - 1))
           : (tick_count >= TICK_W'(STEP_NORMAL - 1));
   end

   gain_ramp #(
      .FLOOR (PLAY_GAIN_MIN),
      .START (PLAY_GAIN_RESET)
   ) u_left_play (
      .clk       (clk),
      .arst_n    (arst_n),
      .tick      (tick),
      .mute_req  (playback_digital_gain[LEFT_MUTE_BIT]),
      .target    (playback_digital_gain[LEFT_GAIN_LSB +: GAIN_W]),
      .live_gain (left_playback_level),
      .silenced  (left_playback_zero),
      .settled   (settled[0])
   );

   gain_ramp #(
      .FLOOR (PLAY_GAIN_MIN),
      .START (PLAY_GAIN_RESET)
   ) u_right_play (
      .clk       (clk),
      .arst_n    (arst_n),
      .tick      (tick),
      .mute_req  (playback_digital_gain[RIGHT_MUTE_BIT]),
      .target    (playback_digital_gain[RIGHT_GAIN_LSB +: GAIN_W]),
      .live_gain (right_playback_level),
      .silenced  (right_playback_zero),
      .settled   (settled[1])
   );

   // Floor of 20h makes lower codes act as mute
   gain_ramp #(
      .FLOOR (LOOP_GAIN_MIN),
      .START (LOOP_GAIN_RESET)
   ) u_left_loop (
      .clk       (clk),
      .arst_n    (arst_n),
      .tick      (tick),
      .mute_req  (analog_loop_gain[LEFT_MUTE_BIT]),
      .target    (analog_loop_gain[LEFT_GAIN_LSB +: GAIN_W]),
      .live_gain (left_loop_level),
      .silenced  (left_loop_cut),
      .settled   (settled[2])
   );

   gain_ramp #(
      .FLOOR (LOOP_GAIN_MIN),
      .START (LOOP_GAIN_RESET)
   ) u_right_loop (
      .clk       (clk),
      .arst_n    (arst_n),
      .tick      (tick),
      .mute_req  (analog_loop_gain[RIGHT_MUTE_BIT]),
      .target    (analog_loop_gain[RIGHT_GAIN_LSB +: GAIN_W]),
      .live_gain (right_loop_level),
      .silenced  (right_loop_cut),
      .settled   (settled[3])
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ramp_done_flag <= 1'b1;
      end else begin
         ramp_done_flag <= &settled;
      end
   end
endmodule
`default_nettype wire

// ### dv/audio_volume_mute_regs_properties.sv
/* Port-level checks for the volume and mute bank.
   Assumes it is bound to audio_volume_mute_regs with short step counts. */
`timescale 1ns/10ps
`default_nettype none
module audio_volume_mute_checker
   import vol_pkg::*;
#(
   parameter int STEP_NORMAL = 4,
   parameter int STEP_HALF   = 8
) (
   input wire logic        clk, arst_n, wr_en, rd_en, ramp_half_rate_select, ramp_done_flag,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wr_data, rd_data,
   input wire logic [6:0]  left_playback_level, right_playback_level,
   input wire logic [6:0]  left_loop_level, right_loop_level,
   input wire logic        left_playback_zero, right_playback_zero, left_loop_cut, right_loop_cut
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   step_one_a: assert property ($changed(left_playback_level) |->
      7'(left_playback_level - $past(left_playback_level)) inside {7'h01, 7'h7F})
      else $error("left gain jumped");
   step_rate_a: assert property ($changed(left_playback_level) |=> $stable(left_playback_level)[*2])
      else $error("gain steps too close");
   half_rate_a: assert property (ramp_half_rate_select && $changed(right_playback_level) |=>
      $stable(right_playback_level)[*6])
      else $error("half rate steps too close");
   left_zero_a: assert property (left_playback_zero |-> left_playback_level == PLAY_GAIN_MIN)
      else $error("left zeros before floor");
   right_zero_a: assert property (right_playback_zero |-> right_playback_level == PLAY_GAIN_MIN)
      else $error("right zeros before floor");
   loop_cut_a: assert property ((left_loop_cut |-> left_loop_level == LOOP_GAIN_MIN) and
      (right_loop_cut |-> right_loop_level == LOOP_GAIN_MIN))
      else $error("loop cut before floor");
   loop_floor_a: assert property (left_loop_level >= LOOP_GAIN_MIN && right_loop_level >= 7'h20)
      else $error("loop gain below floor");
   done_low_a: assert property ($changed(left_playback_level) |-> ##[0:2] !ramp_done_flag)
      else $error("done high while ramping");
   unmute_zero_a: assert property (wr_en && addr == ADDR_PLAYBACK_GAIN && !wr_data[15]
      |-> ##[1:3] !left_playback_zero)
      else $error("left zeros kept after unmute");
   c_zero: cover property ($rose(left_playback_zero));
   c_cut: cover property ($rose(right_loop_cut));
   c_half: cover property (ramp_half_rate_select && $changed(right_playback_level));
endmodule
bind audio_volume_mute_regs audio_volume_mute_checker
   #(.STEP_NORMAL(STEP_NORMAL), .STEP_HALF(STEP_HALF)) u_audio_volume_mute_checker (.*);
`default_nettype wire

// ### dv/test_audio_volume_mute_regs.sv
/* Self-checking bench for the volume and mute bank.
   Assumes step counts shortened to 4 and 8 cycles. */
`timescale 1ns/10ps
`default_nettype none
module test_audio_volume_mute_regs;
   import vol_pkg::*;
   logic        clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, ramp_half_rate_select = 0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wr_data = 16'h0000, rd_data;
   logic        ramp_done_flag, left_playback_zero, right_playback_zero, left_loop_cut, right_loop_cut;
   logic [6:0]  left_playback_level, right_playback_level, left_loop_level, right_loop_level;
   int          n_fail = 0, n_compared = 0;
   audio_volume_mute_regs #(.STEP_NORMAL(4), .STEP_HALF(8)) u_audio_volume_mute_regs (.*);
   always #20 clk = ~clk;
   task automatic chk(input logic [15:0] s, e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      chk(rd_data, e);
   endtask
   // Waits past the done flag's lag, then for the ramps to finish
   task automatic settle(output int n);
      repeat (3) @(negedge clk);
      for (n = 3; n < 4000 && ramp_done_flag !== 1'b1; n++) @(negedge clk);
   endtask
   function automatic logic [6:0] goal(input logic m, input logic [6:0] g, fl);
      return (m || g < fl) ? fl : g;
   endfunction
   task automatic results;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #4000000;
      n_fail++;
      results();
   end
   initial begin
      int n, d, t;
      logic [6:0] g, p, q, r;
      void'($urandom(32'h10b1));
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      rd(ADDR_PLAYBACK_GAIN, PLAY_REG_RESET);
      rd(ADDR_LOOP_GAIN, LOOP_REG_RESET);
      rd(4'h5, 16'h0000);
      p = 7'h00;
      for (int i = 0; i < 6; i++) begin
         g = (i == 0) ? 7'h7F : 7'($urandom % 128);
         ramp_half_rate_select = i[0];
         t = i[0] ? 8 : 4;
         d = (g > p) ? g - p : p - g;
         wr(ADDR_PLAYBACK_GAIN, {1'b0, g, 1'b0, g});
         settle(n);
         chk(16'(n >= (d - 1) * t && n <= d * t + 6), 16'h0001);
         chk({left_playback_level, right_playback_level, left_playback_zero, right_playback_zero}, {g, g, 2'b00});
         wr(ADDR_PLAYBACK_GAIN, {1'b1, g, 1'b0, g});
         settle(n);
         chk({left_playback_level, right_playback_level, left_playback_zero, right_playback_zero}, {7'h00, g, 2'b10});
         wr(ADDR_PLAYBACK_GAIN, {1'b1, g, 1'b1, g});
         settle(n);
         chk({left_playback_level, right_playback_level, left_playback_zero, right_playback_zero}, {7'h00, 7'h00, 2'b11});
         rd(ADDR_PLAYBACK_GAIN, {1'b1, g, 1'b1, g});
         wr(ADDR_PLAYBACK_GAIN, {1'b0, g, 1'b0, g});
         settle(n);
         chk({left_playback_level, right_playback_level, left_playback_zero, right_playback_zero}, {g, g, 2'b00});
         p = g;
         q = (i == 0) ? 7'h1F : 7'($urandom % 128);
         r = (i == 0) ? 7'h20 : 7'($urandom % 128);
         wr(ADDR_LOOP_GAIN, {1'b0, q, 1'b0, r});
         settle(n);
         chk({left_loop_level, right_loop_level, left_loop_cut, right_loop_cut}, {goal(0, q, 7'h20), goal(0, r, 7'h20), q < 7'h20, r < 7'h20});
         wr(ADDR_LOOP_GAIN, {1'b1, q, 1'b1, r});
         settle(n);
         chk({left_loop_level, right_loop_level, left_loop_cut, right_loop_cut}, {7'h20, 7'h20, 2'b11});
         wr(ADDR_LOOP_GAIN, {1'b0, q, 1'b0, r});
         settle(n);
         chk({left_loop_level, right_loop_level}, {2'b00, goal(0, q, 7'h20), goal(0, r, 7'h20)});
         rd(ADDR_LOOP_GAIN, {1'b0, q, 1'b0, r});
      end
      arst_n = 1'b0;
      @(negedge clk);
      arst_n = 1'b1;
      chk({left_playback_level, right_playback_level, left_playback_zero, right_playback_zero}, {14'h0000, 2'b11});
      rd(ADDR_LOOP_GAIN, LOOP_REG_RESET);
      results();
   end
endmodule
`default_nettype wire
